// File: shared/stm_defs.svh
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH

// ***********************
// clock and timing
// ***********************
`define STM_CLK_HZ 20000000
`define STM_PULSE_MAX_US 300
`define STM_SPACING_MS 200
`define STM_PULSE_CYC ((`STM_PULSE_MAX_US * `STM_CLK_HZ) / 1000000)
`define STM_SPACING_CYC ((`STM_SPACING_MS * `STM_CLK_HZ) / 1000)

// ***********************
// widths and reset values
// ***********************
`define STM_CNT_W 23
`define STM_SYNC_RST 1'b0
`define STM_DISP_W 2

`endif

// File: shared/stm_pkg.sv
package stm_pkg;

	// display states, gray along opmode -> dot, opmode -> warning -> fault
	typedef enum logic [1:0] {
		STM_DISP_OPMODE = 2'h0,
		STM_DISP_OPMODE_DOT = 2'h1,
		STM_DISP_WARN = 2'h2,
		STM_DISP_FAULT = 2'h3
	} stm_disp_e;

	// per-path filter states, gray along released -> pulse -> tripped
	typedef enum logic [1:0] {
		STM_FLT_RELEASED = 2'h0,
		STM_FLT_PULSE = 2'h1,
		STM_FLT_TRIPPED = 2'h3
	} stm_flt_e;

endpackage

// File: shared/stm_chan_if.sv
`timescale 1ns/10ps

interface stm_chan_if;
	logic level;
	logic release_ok;
	logic early_pulse;

	modport filt (
		input level,
		output release_ok,
		output early_pulse
	);

	modport mon (
		output level,
		input release_ok,
		input early_pulse
	);
endinterface

// File: core/stm_pulse_filter.sv
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_pulse_filter #(
	parameter int PULSE_CYC = `STM_PULSE_CYC,
	parameter int SPACING_CYC = `STM_SPACING_CYC
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// channel
	stm_chan_if.filt ch
);

	stm_pkg::stm_flt_e state_q, state_d;
	logic [`STM_CNT_W-1:0] width_q, width_d;
	logic [`STM_CNT_W-1:0] space_q, space_d;

	// ***********************
	// elaboration checks
	// ***********************
	generate
		if (PULSE_CYC < 1 || SPACING_CYC < 1 || SPACING_CYC >= (1 << `STM_CNT_W)
			|| PULSE_CYC >= (1 << `STM_CNT_W)) begin : g_bad
			$error("stm_pulse_filter: counts out of range");
		end
	endgenerate

	localparam logic [`STM_CNT_W-1:0] PULSE_LIM = `STM_CNT_W'(PULSE_CYC);
	localparam logic [`STM_CNT_W-1:0] SPACE_LIM = `STM_CNT_W'(SPACING_CYC);

	wire space_busy = (space_q != '0);
	wire width_over = (width_q >= PULSE_LIM);

	// ***********************
	// next state
	// ***********************
	always_comb begin
		state_d = state_q;
		width_d = width_q;
		space_d = space_busy ? space_q - `STM_CNT_W'(1) : space_q;
		case (state_q)
			stm_pkg::STM_FLT_RELEASED: begin
				if (!ch.level) begin
					// a second pulse inside the spacing window trips at once
					if (space_busy) begin
						state_d = stm_pkg::STM_FLT_TRIPPED;
					end else begin
						state_d = stm_pkg::STM_FLT_PULSE;
						width_d = `STM_CNT_W'(1);
					end
				end
			end
			stm_pkg::STM_FLT_PULSE: begin
				if (ch.level) begin
					state_d = stm_pkg::STM_FLT_RELEASED;
					space_d = SPACE_LIM;
				end else if (width_over) begin
					state_d = stm_pkg::STM_FLT_TRIPPED;
				end else begin
					width_d = width_q + `STM_CNT_W'(1);
				end
			end
			stm_pkg::STM_FLT_TRIPPED: begin
				if (ch.level) begin
					state_d = stm_pkg::STM_FLT_RELEASED;
					space_d = '0;
				end
			end
			default: begin
				state_d = stm_pkg::STM_FLT_TRIPPED;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= stm_pkg::STM_FLT_TRIPPED;
			width_q <= '0;
			space_q <= '0;
		end else if (ce_i) begin
			state_q <= state_d;
			width_q <= width_d;
			space_q <= space_d;
		end
	end

	assign ch.release_ok = (state_q != stm_pkg::STM_FLT_TRIPPED);
	assign ch.early_pulse = space_busy;

endmodule

// File: core/stm_monitor.sv
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_monitor #(
	parameter int PULSE_CYC = `STM_PULSE_CYC,
	parameter int SPACING_CYC = `STM_SPACING_CYC
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// configuration, same clock domain
	input wire logic dual_mode_i,
	// pins from the safety controller and the drive
	input wire logic torque_off_release_path_a_i,
	input wire logic torque_off_release_path_b_i,
	input wire logic drive_enable_i,
	// power stage
	output logic torque_release_o,
	// status pins to the safety controller
	output logic inhibitor_state_path_a_o,
	output logic inhibitor_state_path_b_o,
	output logic ready_relay_o,
	// display and diagnostics
	output logic [`STM_DISP_W-1:0] display_o,
	output logic safe_state_o,
	output logic path_mismatch_o,
	output logic pulse_window_o
);

	// ***********************
	// pin synchronisers
	// ***********************
	localparam int NPIN = 3;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_q, s2_q, s3_q, lvl_q;

	assign pin_raw = {drive_enable_i, torque_off_release_path_b_i, torque_off_release_path_a_i};

	// a change counts once the second and third stages agree
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= {NPIN{`STM_SYNC_RST}};
			s2_q <= {NPIN{`STM_SYNC_RST}};
			s3_q <= {NPIN{`STM_SYNC_RST}};
			lvl_q <= {NPIN{`STM_SYNC_RST}};
		end else if (ce_i) begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (s2_q == s3_q) ? s2_q : lvl_q;
		end
	end

	// ***********************
	// per-path pulse filters
	// ***********************
	stm_chan_if ch_if[2] ();

	assign ch_if[0].level = lvl_q[0];
	// single channel: path b is not wired and counts as released
	assign ch_if[1].level = lvl_q[1] | ~dual_mode_i;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_path
			stm_pulse_filter #(
				.PULSE_CYC(PULSE_CYC),
				.SPACING_CYC(SPACING_CYC)
			) u_filt (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.ch(ch_if[gi])
			);
		end
	endgenerate

	// ***********************
	// combined decision
	// ***********************
	function automatic stm_pkg::stm_disp_e disp_of(input logic released, input logic en);
		if (released) begin
			disp_of = en ? stm_pkg::STM_DISP_OPMODE_DOT : stm_pkg::STM_DISP_OPMODE;
		end else begin
			disp_of = en ? stm_pkg::STM_DISP_FAULT : stm_pkg::STM_DISP_WARN;
		end
	endfunction

	wire rel_a = ch_if[0].release_ok;
	wire rel_b = ch_if[1].release_ok;
	wire en_lvl = lvl_q[2];
	wire all_rel = rel_a & rel_b;
	wire mismatch = dual_mode_i & (rel_a ^ rel_b);
	wire both_off = ~rel_a & (~rel_b | ~dual_mode_i);

	stm_pkg::stm_disp_e disp_d;
	assign disp_d = disp_of(all_rel, en_lvl);

	wire torque_d = all_rel & en_lvl;
	wire ready_d = (disp_d != stm_pkg::STM_DISP_FAULT);
	wire window_d = ch_if[0].early_pulse | ch_if[1].early_pulse;

	// ***********************
	// output registers
	// ***********************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			torque_release_o <= 1'b0;
			inhibitor_state_path_a_o <= 1'b0;
			inhibitor_state_path_b_o <= 1'b0;
			ready_relay_o <= 1'b1;
			display_o <= stm_pkg::STM_DISP_WARN;
			safe_state_o <= 1'b0;
			path_mismatch_o <= 1'b0;
			pulse_window_o <= 1'b0;
		end else if (ce_i) begin
			torque_release_o <= torque_d;
			inhibitor_state_path_a_o <= rel_a;
			inhibitor_state_path_b_o <= rel_b;
			ready_relay_o <= ready_d;
			display_o <= disp_d;
			safe_state_o <= both_off;
			path_mismatch_o <= mismatch;
			pulse_window_o <= window_d;
		end
	end

endmodule

// File: test/stm_ctrl_model.sv
`timescale 1ns/10ps

// ***
// safety controller and drive outputs
// ***
module stm_ctrl_model (
	input wire logic clk_sys_i,
	output logic rel_a_o,
	output logic rel_b_o,
	output logic en_o
);
	initial {rel_a_o, rel_b_o, en_o} = 3'h0;
	task automatic drive(input logic a, input logic b, input logic e);
		@(negedge clk_sys_i);
		{rel_a_o, rel_b_o, en_o} <= {a, b, e};
	endtask
	task automatic pulse_a(input int len);
		drive(1'b0, rel_b_o, en_o);
		repeat (len) @(negedge clk_sys_i);
		rel_a_o <= 1'b1;
	endtask
	task automatic stop();
		drive(rel_a_o, rel_b_o, 1'b0);
		repeat (8) @(negedge clk_sys_i);
		drive(1'b0, 1'b0, 1'b0);
	endtask
endmodule

// File: test/stm_monitor_props.sv
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_monitor_props (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic torque_off_release_path_a_i,
	input wire logic drive_enable_i,
	input wire logic torque_release_o,
	input wire logic inhibitor_state_path_a_o,
	input wire logic inhibitor_state_path_b_o,
	input wire logic ready_relay_o,
	input wire logic [`STM_DISP_W-1:0] display_o,
	input wire logic path_mismatch_o
);
	default clocking @(posedge clk_sys_i); endclocking
	// frozen clock enable holds all state, so timing checks pause
	default disable iff (rst_i || !ce_i);
	sequence s_en_drop;
		$fell(drive_enable_i);
	endsequence
	sequence s_pin_was_low;
		!$past(torque_off_release_path_a_i, 5) || !$past(torque_off_release_path_a_i, 6);
	endsequence
	a_torque_needs_paths: assert property (torque_release_o |-> inhibitor_state_path_a_o && inhibitor_state_path_b_o)
		else $error("torque with a path blocked");
	a_dot_means_torque: assert property (torque_release_o == (display_o == 2'h1))
		else $error("dot display and torque differ");
	a_relay_drops_fault: assert property (ready_relay_o != (display_o == 2'h3))
		else $error("ready relay wrong for display");
	a_fault_no_torque: assert property (display_o[1] |-> !torque_release_o)
		else $error("torque in warning or fault");
	a_mismatch_no_run: assert property (path_mismatch_o |-> display_o[1])
		else $error("mismatch without warning or fault");
	a_enable_stops: assert property (s_en_drop |-> ##[1:6] !torque_release_o)
		else $error("torque kept after enable low");
	a_status_from_pin: assert property ($fell(inhibitor_state_path_a_o) |-> s_pin_was_low)
		else $error("status a fell without pin low");
	a_torque_needs_en: assert property ($rose(torque_release_o) |-> $past(drive_enable_i, 3))
		else $error("torque rose without enable");
endmodule

bind stm_monitor stm_monitor_props i_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
	.torque_off_release_path_a_i(torque_off_release_path_a_i), .drive_enable_i(drive_enable_i),
	.torque_release_o(torque_release_o), .inhibitor_state_path_a_o(inhibitor_state_path_a_o),
	.inhibitor_state_path_b_o(inhibitor_state_path_b_o), .ready_relay_o(ready_relay_o),
	.display_o(display_o), .path_mismatch_o(path_mismatch_o));

// File: test/stm_monitor_test.sv
`timescale 1ns/10ps
`include "stm_defs.svh"

module stm_monitor_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic dual = 1'b1;
	logic ce = 1'b1;
	logic ra, rb, en, tq, sa, sb, rdy, safe, mm, win;
	logic [`STM_DISP_W-1:0] disp;
	int error_cnt = 0;
	int n_tests = 0;
	stm_ctrl_model i_ctrl (.clk_sys_i(clk), .rel_a_o(ra), .rel_b_o(rb), .en_o(en));
	stm_monitor #(.PULSE_CYC(6), .SPACING_CYC(40)) i_dut (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce),
		.dual_mode_i(dual), .torque_off_release_path_a_i(ra), .torque_off_release_path_b_i(rb),
		.drive_enable_i(en), .torque_release_o(tq), .inhibitor_state_path_a_o(sa),
		.inhibitor_state_path_b_o(sb), .ready_relay_o(rdy), .display_o(disp), .safe_state_o(safe),
		.path_mismatch_o(mm), .pulse_window_o(win));
	initial forever #25 clk = ~clk;
	// ***
	// checking helpers
	// ***
	task automatic chk(input string n, input logic [1:0] s, input logic [1:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic look(input logic t, input logic a, input logic b, input logic r, input logic [1:0] d);
		chk("torque", tq, t);
		chk("status a", sa, a);
		chk("status b", sb, b);
		chk("ready", rdy, r);
		chk("display", disp, d);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ***
	// scenarios
	// ***
	task automatic t_run();
		i_ctrl.drive(1'b1, 1'b1, 1'b0);
		cyc(8);
		look(1'b0, 1'b1, 1'b1, 1'b1, 2'h0);
		i_ctrl.drive(1'b1, 1'b1, 1'b1);
		cyc(8);
		look(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
		ce = 1'b0;
		i_ctrl.drive(1'b1, 1'b1, 1'b0);
		cyc(8);
		look(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
		ce = 1'b1;
		cyc(8);
		look(1'b0, 1'b1, 1'b1, 1'b1, 2'h0);
		i_ctrl.drive(1'b1, 1'b1, 1'b1);
		cyc(8);
		look(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
		$display("test run done");
	endtask
	task automatic t_pulses();
		i_ctrl.pulse_a(3);
		cyc(8);
		look(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
		chk("window", win, 1'b1);
		i_ctrl.drive(1'b0, 1'b1, 1'b1);
		cyc(8);
		look(1'b0, 1'b0, 1'b1, 1'b0, 2'h3);
		chk("mismatch", mm, 1'b1);
		i_ctrl.drive(1'b1, 1'b1, 1'b1);
		cyc(50);
		look(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
		chk("window", win, 1'b0);
		$display("test pulses done");
	endtask
	task automatic t_long();
		i_ctrl.drive(1'b1, 1'b0, 1'b1);
		cyc(16);
		look(1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
		i_ctrl.stop();
		cyc(16);
		look(1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
		chk("safe", safe, 1'b1);
		$display("test long done");
	endtask
	task automatic t_dyn();
		look(1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
		i_ctrl.drive(1'b1, 1'b0, 1'b0);
		cyc(16);
		look(1'b0, 1'b1, 1'b0, 1'b1, 2'h2);
		i_ctrl.drive(1'b0, 1'b1, 1'b0);
		cyc(16);
		look(1'b0, 1'b0, 1'b1, 1'b1, 2'h2);
		i_ctrl.drive(1'b0, 1'b0, 1'b0);
		cyc(16);
		look(1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
		$display("test dyn done");
	endtask
	task automatic t_single();
		dual = 1'b0;
		i_ctrl.drive(1'b1, 1'b0, 1'b1);
		cyc(16);
		look(1'b1, 1'b1, 1'b1, 1'b1, 2'h1);
		i_ctrl.drive(1'b0, 1'b0, 1'b1);
		cyc(16);
		look(1'b0, 1'b0, 1'b1, 1'b0, 2'h3);
		$display("test single done");
	endtask
	initial begin
		cyc(8);
		look(1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
		rst = 1'b0;
		t_run();
		t_pulses();
		t_long();
		t_dyn();
		t_single();
		complete_run();
	end
	initial begin
		#50us;
		error_cnt++;
		complete_run();
	end
endmodule
